// >>> rtl/rsx_pkg.sv
// Purpose: constants for the rotate/subtract/skip execution unit
// Assumes: 32-bit APB, one aligned word per register
// Notes:   opcodes are the software codes written into the command word
package rsx_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_OPER   = 8'h00;  // data memory operand byte
   localparam logic [7:0] ADDR_WORK   = 8'h04;  // working register
   localparam logic [7:0] ADDR_FLAGS  = 8'h08;  // c, nibble carry, z, signed range
   localparam logic [7:0] ADDR_CMD    = 8'h0c;  // write starts an instruction
   localparam logic [7:0] ADDR_STATUS = 8'h10;  // busy, skip, bad opcode

   // flag bit positions
   localparam int FLAG_C             = 0;
   localparam int FLAG_NIBBLE_CARRY  = 1;
   localparam int FLAG_Z             = 2;
   localparam int FLAG_SIGNED_RANGE  = 3;

   // status bit positions
   localparam int STAT_BUSY = 0;
   localparam int STAT_SKIP = 1;
   localparam int STAT_BAD  = 2;

   // command word fields
   localparam int CMD_OP_LSB  = 0;   // opcode in [4:0]
   localparam int CMD_BIT_LSB = 8;   // bit select in [10:8]
   localparam int CMD_IMM_LSB = 16;  // immediate in [23:16]

   // reset values
   localparam logic [7:0] OPER_RST  = 8'h00;
   localparam logic [7:0] WORK_RST  = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [4:0] CMD_RST   = 5'h1f;

   // instruction codes
   localparam logic [4:0] OP_ROTATE_LEFT_TO_WORKING          = 5'h00;
   localparam logic [4:0] OP_ROTATE_LEFT_THROUGH_CARRY       = 5'h01;
   localparam logic [4:0] OP_ROTATE_LEFT_CARRY_TO_WORKING    = 5'h02;
   localparam logic [4:0] OP_ROTATE_RIGHT                    = 5'h03;
   localparam logic [4:0] OP_ROTATE_RIGHT_TO_WORKING         = 5'h04;
   localparam logic [4:0] OP_ROTATE_RIGHT_THROUGH_CARRY      = 5'h05;
   localparam logic [4:0] OP_ROTATE_RIGHT_CARRY_TO_WORKING   = 5'h06;
   localparam logic [4:0] OP_MINUS_WITH_BORROW               = 5'h07;
   localparam logic [4:0] OP_MINUS_WITH_BORROW_TO_MEMORY     = 5'h08;
   localparam logic [4:0] OP_MINUS                           = 5'h09;
   localparam logic [4:0] OP_MINUS_INTO_MEMORY               = 5'h0a;
   localparam logic [4:0] OP_MINUS_IMMEDIATE                 = 5'h0b;
   localparam logic [4:0] OP_DECREMENT_SKIP_ON_NULL          = 5'h0c;
   localparam logic [4:0] OP_DECREMENT_SKIP_ON_NULL_TO_WORK  = 5'h0d;
   localparam logic [4:0] OP_INCREMENT_SKIP_ON_NULL          = 5'h0e;
   localparam logic [4:0] OP_INCREMENT_SKIP_ON_NULL_TO_WORK  = 5'h0f;
   localparam logic [4:0] OP_SKIP_ON_BIT_HIGH                = 5'h10;
   localparam logic [4:0] OP_SET_BYTE                        = 5'h11;
   localparam logic [4:0] OP_SET_BIT                         = 5'h12;

   // execution sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DUMMY} exec_state_type;
endpackage

// >>> rtl/rotate_subtract_skip_exec.sv
// Purpose: execution unit for rotates, subtracts, skips and set ops
// Assumes: memory operand and working register loaded over APB first
// Notes:   skip-type instructions hold busy for two cycles
// What this block does
// RULE1: rotate left into working, flags untouched
// RULE2: rotate memory left through carry
// RULE3: rotate left through carry into working
// RULE4: rotate memory right, flags untouched
// RULE5: rotate right into working, carry kept
// RULE6: rotate right through carry, memory or working
// RULE7: working minus memory minus inverted carry
// RULE8: borrow subtract result into memory
// RULE9: carry clear on negative, else set
// RULE10: plain subtract, working or memory target
// RULE11: subtract immediate from working
// RULE12: decrement memory, skip when zero
// RULE13: decrement into working, skip when zero
// RULE14: increment memory, skip when zero
// RULE15: increment into working, skip when zero
// RULE16: skip when selected bit is set
// RULE17: skip instructions take two cycles
// RULE18: set byte writes all ones
// RULE19: set bit forces one bit high
// RULE20: increment and decrement wrap modulo 256
// RULE21: subtract sets z, overflow, nibble carry
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
module rotate_subtract_skip_exec #(
   parameter int ADDR_W = 8                      // apb address width
) (
   input  wire logic              pclk,          // 50 mhz clock
   input  wire logic              presetn,       // async reset, low
   input  wire logic              psel,          // apb select
   input  wire logic              penable,       // apb access phase
   input  wire logic              pwrite,        // apb write
   input  wire logic [ADDR_W-1:0] paddr,         // apb byte address
   input  wire logic [31:0]       pwdata,        // apb write data
   output logic      [31:0]       prdata,        // apb read data
   output logic                   pready,        // apb ready
   output logic                   pslverr,       // apb error
   output logic                   skip_next      // next instruction skipped
);
   // bus state
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   // core state
   rsx_pkg::exec_state_type state_r, state_nxt;
   logic [7:0]  oper_r, oper_nxt;
   logic [7:0]  work_r, work_nxt;
   logic [3:0]  flags_r, flags_nxt;
   logic [4:0]  op_r, op_nxt;
   logic [2:0]  bsel_r, bsel_nxt;
   logic [7:0]  imm_r, imm_nxt;
   logic        skip_r, skip_nxt;
   logic        bad_r, bad_nxt;
   // decoded bus strokes
   logic        access, hit, busy, wr_ok;
   logic [7:0]  offs;

   // true for the instructions that may skip
   function automatic logic is_skip_op(input logic [4:0] op);
      is_skip_op = (op >= rsx_pkg::OP_DECREMENT_SKIP_ON_NULL) &&
                   (op <= rsx_pkg::OP_SKIP_ON_BIT_HIGH);
   endfunction

   // subtract a - b - borrow, returns {srange, nibble, c, z, result}
   function automatic logic [11:0] sub_flags(input logic [7:0] a, input logic [7:0] b,
                                             input logic cin);
      logic [8:0] d;
      logic [4:0] lo;
      logic       sr;
      d  = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
      lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
      sr = (a[7] ^ b[7]) & (a[7] ^ d[7]);
      sub_flags = {sr, ~lo[4], ~d[8], (d[7:0] == 8'h00), d[7:0]};
   endfunction

   assign offs   = 8'(paddr);
   assign access = psel & penable & pready_r;
   assign busy   = (state_r != rsx_pkg::ST_IDLE);
   assign hit    = (offs == rsx_pkg::ADDR_OPER) || (offs == rsx_pkg::ADDR_WORK) ||
                   (offs == rsx_pkg::ADDR_FLAGS) || (offs == rsx_pkg::ADDR_CMD) ||
                   (offs == rsx_pkg::ADDR_STATUS);
   assign wr_ok  = access & pwrite & hit & ~busy & (offs != rsx_pkg::ADDR_STATUS);

   // apb answer: one wait state, error on unmapped access or on busy or status write
   always_comb begin
      pready_nxt  = psel & penable & ~pready_r;
      pslverr_nxt = 1'b0;
      prdata_nxt  = prdata_r;
      if (pready_nxt) begin
         // busy as it will stand at the edge that takes the write
         pslverr_nxt = ~hit | (pwrite & ((state_nxt != rsx_pkg::ST_IDLE) |
                                         (offs == rsx_pkg::ADDR_STATUS)));
         prdata_nxt  = 32'h0000_0000;
         if (!pwrite) begin
            case (offs)
               rsx_pkg::ADDR_OPER:   prdata_nxt = {24'h00_0000, oper_r};
               rsx_pkg::ADDR_WORK:   prdata_nxt = {24'h00_0000, work_r};
               rsx_pkg::ADDR_FLAGS:  prdata_nxt = {28'h000_0000, flags_r};
               rsx_pkg::ADDR_CMD:    prdata_nxt = {8'h00, imm_r, 5'h00, bsel_r, 3'h0, op_r};
               rsx_pkg::ADDR_STATUS: prdata_nxt = {29'h0000_0000, bad_r, skip_r, busy};
               default:              prdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   // bus registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
         prdata_r  <= prdata_nxt;
      end
   end

   // register writes, sequencer and datapath
   always_comb begin
      logic [11:0] s;
      logic [7:0]  m, a, st;
      logic        c;
      s         = 12'h000;
      m         = oper_r;
      a         = work_r;
      c         = flags_r[rsx_pkg::FLAG_C];
      st        = 8'h00;
      state_nxt = state_r;
      oper_nxt  = oper_r;
      work_nxt  = work_r;
      flags_nxt = flags_r;
      op_nxt    = op_r;
      bsel_nxt  = bsel_r;
      imm_nxt   = imm_r;
      skip_nxt  = skip_r;
      bad_nxt   = bad_r;
      if (wr_ok) begin
         case (offs)
            rsx_pkg::ADDR_OPER:  oper_nxt  = pwdata[7:0];
            rsx_pkg::ADDR_WORK:  work_nxt  = pwdata[7:0];
            rsx_pkg::ADDR_FLAGS: flags_nxt = pwdata[3:0];
            rsx_pkg::ADDR_CMD: begin
               op_nxt    = pwdata[rsx_pkg::CMD_OP_LSB +: 5];
               bsel_nxt  = pwdata[rsx_pkg::CMD_BIT_LSB +: 3];
               imm_nxt   = pwdata[rsx_pkg::CMD_IMM_LSB +: 8];
               skip_nxt  = 1'b0;
               bad_nxt   = 1'b0;
               state_nxt = rsx_pkg::ST_EXEC;
            end
            default: ;
         endcase
      end
      unique case (state_r)
         rsx_pkg::ST_IDLE: ;
         rsx_pkg::ST_DUMMY: state_nxt = rsx_pkg::ST_IDLE;
         rsx_pkg::ST_EXEC: begin
            // skip ops spend a dummy cycle while the next one is fetched
            state_nxt = is_skip_op(op_r) ? rsx_pkg::ST_DUMMY : rsx_pkg::ST_IDLE; // RULE17
            case (op_r)
               rsx_pkg::OP_ROTATE_LEFT_TO_WORKING:
                  work_nxt = {m[6:0], m[7]};                               // RULE1
               rsx_pkg::OP_ROTATE_LEFT_THROUGH_CARRY: begin
                  oper_nxt = {m[6:0], c};                                  // RULE2
                  flags_nxt[rsx_pkg::FLAG_C] = m[7];
               end
               rsx_pkg::OP_ROTATE_LEFT_CARRY_TO_WORKING: begin
                  work_nxt = {m[6:0], c};                                  // RULE3
                  flags_nxt[rsx_pkg::FLAG_C] = m[7];
               end
               rsx_pkg::OP_ROTATE_RIGHT:
                  oper_nxt = {m[0], m[7:1]};                               // RULE4
               rsx_pkg::OP_ROTATE_RIGHT_TO_WORKING:
                  work_nxt = {m[0], m[7:1]};                               // RULE5
               rsx_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY: begin
                  oper_nxt = {c, m[7:1]};                                  // RULE6
                  flags_nxt[rsx_pkg::FLAG_C] = m[0];
               end
               rsx_pkg::OP_ROTATE_RIGHT_CARRY_TO_WORKING: begin
                  work_nxt = {c, m[7:1]};                                  // RULE6
                  flags_nxt[rsx_pkg::FLAG_C] = m[0];
               end
               rsx_pkg::OP_MINUS_WITH_BORROW, rsx_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY,
               rsx_pkg::OP_MINUS, rsx_pkg::OP_MINUS_INTO_MEMORY,
               rsx_pkg::OP_MINUS_IMMEDIATE: begin
                  // borrow ops feed inverted carry, the others no borrow
                  if (op_r == rsx_pkg::OP_MINUS_IMMEDIATE)
                     s = sub_flags(a, imm_r, 1'b1);                        // RULE11
                  else if (op_r == rsx_pkg::OP_MINUS_WITH_BORROW ||
                           op_r == rsx_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY)
                     s = sub_flags(a, m, c);                               // RULE7
                  else
                     s = sub_flags(a, m, 1'b1);                            // RULE10
                  if (op_r == rsx_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY ||
                      op_r == rsx_pkg::OP_MINUS_INTO_MEMORY)
                     oper_nxt = s[7:0];                                    // RULE8
                  else
                     work_nxt = s[7:0];
                  flags_nxt[rsx_pkg::FLAG_C]  = s[9];                      // RULE9
                  flags_nxt[rsx_pkg::FLAG_Z]  = s[8];                      // RULE21
                  flags_nxt[rsx_pkg::FLAG_NIBBLE_CARRY] = s[10];           // RULE21
                  flags_nxt[rsx_pkg::FLAG_SIGNED_RANGE] = s[11];           // RULE21
               end
               rsx_pkg::OP_DECREMENT_SKIP_ON_NULL,
               rsx_pkg::OP_DECREMENT_SKIP_ON_NULL_TO_WORK,
               rsx_pkg::OP_INCREMENT_SKIP_ON_NULL,
               rsx_pkg::OP_INCREMENT_SKIP_ON_NULL_TO_WORK: begin
                  // 8-bit arithmetic wraps on its own
                  if (op_r[1])
                     st = m + 8'h01;                                       // RULE14 RULE20
                  else
                     st = m - 8'h01;                                       // RULE12 RULE20
                  if (op_r[0])
                     work_nxt = st;                                        // RULE13 RULE15
                  else
                     oper_nxt = st;
                  skip_nxt = (st == 8'h00);
               end
               rsx_pkg::OP_SKIP_ON_BIT_HIGH:
                  skip_nxt = m[bsel_r];                                    // RULE16
               rsx_pkg::OP_SET_BYTE:
                  oper_nxt = 8'hff;                                        // RULE18
               rsx_pkg::OP_SET_BIT:
                  oper_nxt = m | (8'h01 << bsel_r);                        // RULE19
               default:
                  bad_nxt = 1'b1;
            endcase
         end
      endcase
   end

   // core registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= rsx_pkg::ST_IDLE;
         oper_r  <= rsx_pkg::OPER_RST;
         work_r  <= rsx_pkg::WORK_RST;
         flags_r <= rsx_pkg::FLAGS_RST;
         op_r    <= rsx_pkg::CMD_RST;
         bsel_r  <= 3'h0;
         imm_r   <= 8'h00;
         skip_r  <= 1'b0;
         bad_r   <= 1'b0;
      end else begin
         state_r <= state_nxt;
         oper_r  <= oper_nxt;
         work_r  <= work_nxt;
         flags_r <= flags_nxt;
         op_r    <= op_nxt;
         bsel_r  <= bsel_nxt;
         imm_r   <= imm_nxt;
         skip_r  <= skip_nxt;
         bad_r   <= bad_nxt;
      end
   end

   assign prdata    = prdata_r;
   assign pready    = pready_r;
   assign pslverr   = pslverr_r;
   assign skip_next = skip_r;

   // checks on the execution cycle
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic exec;
   assign exec = (state_r == rsx_pkg::ST_EXEC);

   sequence two_cycle_seq;
      (state_r == rsx_pkg::ST_DUMMY) ##1 (state_r == rsx_pkg::ST_IDLE);
   endsequence

   skip_two_cycles_a: assert property (exec && is_skip_op(op_r) |=> two_cycle_seq) // RULE17
      else $error("skip instruction did not take two cycles");
   rotl_working_a: assert property (exec && op_r == rsx_pkg::OP_ROTATE_LEFT_TO_WORKING // RULE1
      |=> work_r == {$past(oper_r[6:0]), $past(oper_r[7])} && $stable(oper_r) && $stable(flags_r))
      else $error("rotate left to working wrong");
   rotl_carry_a: assert property (exec && op_r == rsx_pkg::OP_ROTATE_LEFT_THROUGH_CARRY // RULE2
      |=> oper_r == {$past(oper_r[6:0]), $past(flags_r[0])} && flags_r[0] == $past(oper_r[7]))
      else $error("rotate left through carry wrong");
   rotr_carry_a: assert property (exec && op_r == rsx_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY // RULE6
      |=> oper_r == {$past(flags_r[0]), $past(oper_r[7:1])} && flags_r[0] == $past(oper_r[0]))
      else $error("rotate right through carry wrong");
   rotr_mem_a: assert property (exec && op_r == rsx_pkg::OP_ROTATE_RIGHT // RULE4
      |=> oper_r == {$past(oper_r[0]), $past(oper_r[7:1])} && $stable(flags_r))
      else $error("rotate right wrong");
   sub_carry_a: assert property (exec && op_r == rsx_pkg::OP_MINUS // RULE9
      |=> flags_r[0] == ($past(work_r) >= $past(oper_r)))
      else $error("subtract carry wrong");
   dec_skip_a: assert property (exec && op_r == rsx_pkg::OP_DECREMENT_SKIP_ON_NULL // RULE12
      |=> oper_r == 8'($past(oper_r) - 8'h01) && skip_r == ($past(oper_r) == 8'h01))
      else $error("decrement skip wrong");
   inc_wrap_a: assert property (exec && op_r == rsx_pkg::OP_INCREMENT_SKIP_ON_NULL // RULE20
      && oper_r == 8'hff |=> oper_r == 8'h00 && skip_r ##1 skip_r)
      else $error("increment wrap did not skip");
   bit_skip_a: assert property (exec && op_r == rsx_pkg::OP_SKIP_ON_BIT_HIGH // RULE16
      |=> skip_r == $past(oper_r[bsel_r]) && $stable(flags_r))
      else $error("bit skip wrong");
   set_byte_a: assert property (exec && op_r == rsx_pkg::OP_SET_BYTE // RULE18
      |=> oper_r == 8'hff && $stable(flags_r))
      else $error("set byte wrong");
   set_bit_a: assert property (exec && op_r == rsx_pkg::OP_SET_BIT // RULE19
      |=> oper_r == ($past(oper_r) | (8'h01 << $past(bsel_r))))
      else $error("set bit wrong");

   // left carry rotate into working
   rotl_cwork_a: assert property ( // RULE3
      exec && op_r == rsx_pkg::OP_ROTATE_LEFT_CARRY_TO_WORKING
      |=> work_r == {$past(oper_r[6:0]), $past(flags_r[0])}
      && flags_r[0] == $past(oper_r[7]) && $stable(oper_r))
      else $error("rotate left carry to working wrong");

   // right rotate into working
   rotr_work_a: assert property ( // RULE5
      exec && op_r == rsx_pkg::OP_ROTATE_RIGHT_TO_WORKING
      |=> work_r == {$past(oper_r[0]), $past(oper_r[7:1])}
      && $stable(oper_r) && $stable(flags_r))
      else $error("rotate right to working wrong");

   // right carry rotate into working
   rotr_cwork_a: assert property ( // RULE6
      exec && op_r == rsx_pkg::OP_ROTATE_RIGHT_CARRY_TO_WORKING
      |=> work_r == {$past(flags_r[0]), $past(oper_r[7:1])}
      && flags_r[0] == $past(oper_r[0]) && $stable(oper_r))
      else $error("rotate right carry to working wrong");

   // borrow subtract into working
   borrow_work_a: assert property ( // RULE7
      exec && op_r == rsx_pkg::OP_MINUS_WITH_BORROW
      |=> work_r == 8'($past(work_r) - $past(oper_r) - 8'(!$past(flags_r[0])))
      && $stable(oper_r))
      else $error("borrow subtract wrong");

   // borrow subtract into memory
   borrow_mem_a: assert property ( // RULE8
      exec && op_r == rsx_pkg::OP_MINUS_WITH_BORROW_TO_MEMORY
      |=> oper_r == 8'($past(work_r) - $past(oper_r) - 8'(!$past(flags_r[0])))
      && $stable(work_r))
      else $error("borrow subtract to memory wrong");

   // plain subtract into memory
   minus_mem_a: assert property ( // RULE10
      exec && op_r == rsx_pkg::OP_MINUS_INTO_MEMORY
      |=> oper_r == 8'($past(work_r) - $past(oper_r))
      && $stable(work_r))
      else $error("subtract into memory wrong");

   // immediate subtract into working
   minus_imm_a: assert property ( // RULE11
      exec && op_r == rsx_pkg::OP_MINUS_IMMEDIATE
      |=> work_r == 8'($past(work_r) - $past(imm_r))
      && $stable(oper_r))
      else $error("subtract immediate wrong");

   // zero and signed range flags
   sub_zero_a: assert property ( // RULE21
      exec && op_r == rsx_pkg::OP_MINUS
      |=> flags_r[2] == (work_r == 8'h00) && flags_r[3] ==
      (($past(work_r[7]) != $past(oper_r[7])) && (work_r[7] != $past(work_r[7]))))
      else $error("subtract zero or signed range flag wrong");

   // decrement into working
   dec_work_a: assert property ( // RULE13
      exec && op_r == rsx_pkg::OP_DECREMENT_SKIP_ON_NULL_TO_WORK
      |=> work_r == 8'($past(oper_r) - 8'h01)
      && skip_r == (work_r == 8'h00) && $stable(oper_r))
      else $error("decrement to working wrong");

   // increment into working
   inc_work_a: assert property ( // RULE15
      exec && op_r == rsx_pkg::OP_INCREMENT_SKIP_ON_NULL_TO_WORK
      |=> work_r == 8'($past(oper_r) + 8'h01)
      && skip_r == (work_r == 8'h00) && $stable(oper_r))
      else $error("increment to working wrong");
endmodule

// >>> bench/rotate_subtract_skip_exec_tb_top.sv
// Purpose: self-checking bench for the rotate/subtract/skip execution unit
// Assumes: apb master with one idle cycle between transfers unless held
// Notes:   expected values come from a small behavioural model in the bench
`timescale 1ns/10ps
module rotate_subtract_skip_exec_tb_top;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        skip_next;
   int          fails;
   int          check_count;

   // device under test
   rotate_subtract_skip_exec #(.ADDR_W(8)) u_dut (
      .pclk      (pclk),
      .presetn   (presetn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pwdata    (pwdata),
      .prdata    (prdata),
      .pready    (pready),
      .pslverr   (pslverr),
      .skip_next (skip_next)
   );

   // 50 mhz clock
   always #10 pclk = ~pclk;

   // compare one value, count and report
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // verdict and end of run
   task automatic wrap_up;
      if (fails == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // one apb transfer; keep leaves psel up for a back-to-back setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic keep, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      if (n >= 20) fails++;
      if (!keep) begin
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, 1'b0, r, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, 32'h0, 1'b0, r, e);
   endtask

   // reference behaviour of one instruction
   function automatic void model(input logic [4:0] op, input logic [2:0] b,
      input logic [7:0] imm, input logic [7:0] m, input logic [7:0] a,
      input logic [3:0] f, output logic [7:0] em, output logic [7:0] ea,
      output logic [3:0] ef, output logic sk);
      logic [8:0] d;
      logic [4:0] n;
      logic [7:0] y;
      logic       bi;
      em = m;
      ea = a;
      ef = f;
      sk = 1'b0;
      y = m;
      bi = 1'b0;
      case (op)
         5'h00: ea = {m[6:0], m[7]};
         5'h01: begin em = {m[6:0], f[0]}; ef[0] = m[7]; end
         5'h02: begin ea = {m[6:0], f[0]}; ef[0] = m[7]; end
         5'h03: em = {m[0], m[7:1]};
         5'h04: ea = {m[0], m[7:1]};
         5'h05: begin em = {f[0], m[7:1]}; ef[0] = m[0]; end
         5'h06: begin ea = {f[0], m[7:1]}; ef[0] = m[0]; end
         5'h0c: begin em = m - 8'h01; sk = (em == 8'h00); end
         5'h0d: begin ea = m - 8'h01; sk = (ea == 8'h00); end
         5'h0e: begin em = m + 8'h01; sk = (em == 8'h00); end
         5'h0f: begin ea = m + 8'h01; sk = (ea == 8'h00); end
         5'h10: sk = m[b];
         5'h11: em = 8'hff;
         5'h12: em[b] = 1'b1;
         default: ;
      endcase
      if (op >= 5'h07 && op <= 5'h0b) begin
         if (op == 5'h0b) y = imm;
         if (op <= 5'h08) bi = ~f[0];
         d = {1'b0, a} - {1'b0, y} - {8'h00, bi};
         n = {1'b0, a[3:0]} - {1'b0, y[3:0]} - {4'h0, bi};
         ef = {(a[7] != y[7]) && (d[7] != a[7]), d[7:0] == 8'h00, ~n[4], ~d[8]};
         if (op == 5'h08 || op == 5'h0a) em = d[7:0];
         else ea = d[7:0];
      end
   endfunction

   // load operands, issue one instruction, compare every result
   task automatic run(input logic [4:0] op, input logic [2:0] b, input logic [7:0] imm,
                      input logic [7:0] m, input logic [7:0] a, input logic [3:0] f);
      logic [7:0]  em;
      logic [7:0]  ea;
      logic [3:0]  ef;
      logic        sk;
      logic [31:0] r;
      int          n;
      model(op, b, imm, m, a, f, em, ea, ef, sk);
      wr(rsx_pkg::ADDR_OPER, {24'h0, m});
      wr(rsx_pkg::ADDR_WORK, {24'h0, a});
      wr(rsx_pkg::ADDR_FLAGS, {28'h0, f});
      wr(rsx_pkg::ADDR_CMD, {8'h0, imm, 5'h0, b, 3'h0, op});
      n = 0;
      do begin
         rd(rsx_pkg::ADDR_STATUS, r);
         n++;
      end while (r[0] !== 1'b0 && n < 10);
      check(r, {29'h0, op > 5'h12, sk, 1'b0});
      check({31'h0, skip_next}, {31'h0, sk});
      rd(rsx_pkg::ADDR_OPER, r);
      check(r, {24'h0, em});
      rd(rsx_pkg::ADDR_WORK, r);
      check(r, {24'h0, ea});
      rd(rsx_pkg::ADDR_FLAGS, r);
      check(r, {28'h0, ef});
   endtask

   // reset values of the command, operand and flags registers
   task automatic t_reset;
      logic [31:0] r;
      rd(rsx_pkg::ADDR_CMD, r);
      check(r, 32'h0000001f);
      rd(rsx_pkg::ADDR_OPER, r);
      check(r, 32'h0);
      rd(rsx_pkg::ADDR_FLAGS, r);
      check(r, 32'h0);
   endtask

   // all seven rotates, with carry in both states
   task automatic t_rotates;
      for (int c = 0; c < 2; c++) begin
         for (int op = 0; op < 7; op++) begin
            run(op[4:0], 3'h0, 8'h00, 8'h81, 8'h5a, {3'h5, c[0]});
            run(op[4:0], 3'h0, 8'h00, 8'h6e, 8'h00, {3'h2, c[0]});
         end
      end
   endtask

   // subtracts: borrow in, zero, signed overflow, nibble borrow, immediate
   task automatic t_subtracts;
      run(5'h07, 3'h0, 8'h00, 8'h20, 8'h10, 4'h0);
      run(5'h07, 3'h0, 8'h00, 8'h05, 8'h06, 4'h0);
      run(5'h08, 3'h0, 8'h00, 8'h01, 8'h10, 4'h1);
      run(5'h08, 3'h0, 8'h00, 8'h7f, 8'h80, 4'h0);
      run(5'h09, 3'h0, 8'h00, 8'h01, 8'h80, 4'h0);
      run(5'h0a, 3'h0, 8'h00, 8'h05, 8'h05, 4'h0);
      run(5'h0b, 3'h0, 8'h01, 8'h33, 8'h10, 4'hf);
      run(5'h0b, 3'h0, 8'h90, 8'h00, 8'h10, 4'h0);
   endtask

   // skips on both outcomes, wrap at both ends, bit test at edges
   task automatic t_skips;
      run(5'h0c, 3'h0, 8'h00, 8'h01, 8'h44, 4'h0);
      run(5'h0c, 3'h0, 8'h00, 8'h00, 8'h44, 4'hf);
      run(5'h0d, 3'h0, 8'h00, 8'h01, 8'h44, 4'h0);
      run(5'h0d, 3'h0, 8'h00, 8'h09, 8'h44, 4'h0);
      run(5'h0e, 3'h0, 8'h00, 8'hff, 8'h44, 4'h0);
      run(5'h0e, 3'h0, 8'h00, 8'h10, 8'h44, 4'ha);
      run(5'h0f, 3'h0, 8'h00, 8'hff, 8'h44, 4'h0);
      run(5'h0f, 3'h0, 8'h00, 8'h05, 8'h44, 4'h0);
      run(5'h10, 3'h7, 8'h00, 8'h80, 8'h44, 4'h5);
      run(5'h10, 3'h0, 8'h00, 8'hfe, 8'h44, 4'h0);
   endtask

   // set byte and set bit
   task automatic t_sets;
      run(5'h11, 3'h0, 8'h00, 8'h12, 8'h44, 4'h6);
      run(5'h12, 3'h3, 8'h00, 8'h00, 8'h44, 4'h9);
      run(5'h12, 3'h7, 8'h00, 8'h7f, 8'h44, 4'h0);
   endtask

   // command right behind a skip command, then refused accesses
   task automatic t_refuse;
      logic [31:0] r;
      logic        e;
      wr(rsx_pkg::ADDR_OPER, 32'h01);
      apb(1'b1, rsx_pkg::ADDR_CMD, 32'h0c, 1'b1, r, e);
      apb(1'b1, rsx_pkg::ADDR_CMD, 32'h11, 1'b0, r, e);
      check({31'h0, e}, 32'h0);
      repeat (3) @(posedge pclk);
      check({31'h0, skip_next}, 32'h0);
      rd(rsx_pkg::ADDR_OPER, r);
      check(r, 32'hff);
      apb(1'b0, 8'h14, 32'h0, 1'b0, r, e);
      check({31'h0, e}, 32'h1);
      apb(1'b1, rsx_pkg::ADDR_STATUS, 32'h7, 1'b0, r, e);
      check({31'h0, e}, 32'h1);
      run(5'h13, 3'h0, 8'h00, 8'h3c, 8'hc3, 4'h5);
      run(5'h1f, 3'h0, 8'h00, 8'h3c, 8'hc3, 4'ha);
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      wrap_up;
   end

   // reset then all scenarios
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fails = 0;
      check_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset;
      t_rotates;
      t_subtracts;
      t_skips;
      t_sets;
      t_refuse;
      wrap_up;
   end
endmodule
